// *** hdl/uart_fc_pkg.sv ***
// Shared constants and state types for the UART FIFO trigger and flow control block.
// Assumes one system clock; all pin inputs arrive synchronous to it.
package uart_fc_pkg;
  localparam int FIFO_DEPTH = 64;
  localparam int LVL_W = 7;
  localparam int CHAR_W = 8;
  localparam int ERR_W = 3;
  localparam int DIV_W = 16;
  localparam int OVS_W = 4;
  localparam logic [OVS_W-1:0] OVS_LAST = 4'hF;
  localparam logic [OVS_W-1:0] OVS_MID = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int ERR_FRM = 0;
  localparam int ERR_BRK = 1;
  localparam int ERR_OVR = 2;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_AUTO_CTS = 7;
  localparam int FCR_RX_LSB = 6;
  localparam int FCR_TX_LSB = 4;
  localparam int NIB_LO = 0;
  localparam int NIB_HI = 4;
  localparam int NIB_UNIT_SH = 2;
  localparam logic [LVL_W-1:0] LVL_ONE = 7'h01;
  localparam logic [LVL_W-1:0] LVL_ZERO = 7'h00;
  localparam logic [LVL_W-1:0] RX_SEL_0 = 7'h08;
  localparam logic [LVL_W-1:0] RX_SEL_1 = 7'h10;
  localparam logic [LVL_W-1:0] RX_SEL_2 = 7'h38;
  localparam logic [LVL_W-1:0] RX_SEL_3 = 7'h3C;
  localparam logic [LVL_W-1:0] TX_SEL_0 = 7'h08;
  localparam logic [LVL_W-1:0] TX_SEL_1 = 7'h10;
  localparam logic [LVL_W-1:0] TX_SEL_2 = 7'h20;
  localparam logic [LVL_W-1:0] TX_SEL_3 = 7'h38;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic RTS_OFF = 1'b1;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage : uart_fc_pkg

// *** hdl/uart_fc_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides and an occupancy count.
// Assumes DEPTH is a power of two so the pointers wrap naturally.
`timescale 1ns/10ps
`default_nettype none
module uart_fc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } fifo_s;
  fifo_s st_reg;
  fifo_s st_next;
  logic push;
  logic pop;

  assign push = in_valid_i && (st_reg.cnt != (AW+1)'(DEPTH));
  assign pop = out_ready_i && (st_reg.cnt != '0);

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data_i;
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready_o = st_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = st_reg.cnt != '0;
  assign out_data_o = st_reg.mem[st_reg.rd];
  assign level_o = st_reg.cnt;
endmodule : uart_fc_fifo
`default_nettype wire

// *** hdl/uart_fc_baud.sv ***
// Baud generator: one-cycle tick every divisor clocks, sixteen ticks per bit.
// Assumes the divisor is static while characters are moving.
`timescale 1ns/10ps
`default_nettype none
module uart_fc_baud (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [uart_fc_pkg::DIV_W-1:0] divisor_i,
  output logic tick_o
);
  import uart_fc_pkg::*;
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } baud_s;
  baud_s st_reg;
  baud_s st_next;

  // A zero divisor is outside the usable range, so the generator stops.
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (divisor_i == '0) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= divisor_i - 1'b1) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;
endmodule : uart_fc_baud
`default_nettype wire

// *** hdl/uart_fc_top.sv ***
// UART channel with FIFO trigger levels, auto RTS/CTS flow control and host strap decode.
// Assumes inputs synchronous to clk_sys_i; characters are 8 data bits, no parity, one stop.
`timescale 1ns/10ps
`default_nettype none
module uart_fc_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic host_sel_i,
  input wire logic addr_sel_hi_or_serial_in_i,
  input wire logic addr_sel_lo_or_chip_select_n_i,
  output logic i2c_mode_o,
  output logic [1:0] i2c_addr_sel_o,
  output logic spi_cs_active_o,
  output logic spi_data_in_o,
  input wire logic fifo_en_i,
  input wire logic [7:0] fifo_control_reg_i,
  input wire logic [7:0] trigger_level_reg_i,
  input wire logic [7:0] transmission_control_reg_i,
  input wire logic [7:0] enhanced_features_reg_i,
  input wire logic [uart_fc_pkg::DIV_W-1:0] divisor_i,
  input wire logic [uart_fc_pkg::CHAR_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [uart_fc_pkg::CHAR_W-1:0] rx_data_o,
  output logic [uart_fc_pkg::ERR_W-1:0] rx_err_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [uart_fc_pkg::LVL_W-1:0] rx_level_o,
  output logic [uart_fc_pkg::LVL_W-1:0] tx_level_o,
  output logic rx_trig_o,
  output logic tx_trig_o,
  output logic cts_change_o,
  output logic [7:0] status_o,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic cts_n_i,
  output logic rts_n_o
);
  import uart_fc_pkg::*;

  typedef struct packed {
    tx_state_e tx_st;
    rx_state_e rx_st;
    logic [OVS_W-1:0] tx_cnt;
    logic [OVS_W-1:0] rx_cnt;
    logic [2:0] tx_bit;
    logic [2:0] rx_bit;
    logic [CHAR_W-1:0] tx_sh;
    logic [CHAR_W-1:0] rx_sh;
    logic txd;
    logic rts_n;
    logic cts_prev;
    logic cts_change;
    logic ovr_pend;
    logic strap_done;
    logic i2c_mode;
    logic [1:0] i2c_addr;
    logic spi_cs;
    logic spi_din;
    logic rx_trig;
    logic tx_trig;
    logic [7:0] status;
  } top_s;
  top_s st_reg;
  top_s st_next;

  logic tick;
  logic tx_pop;
  logic tx_avail;
  logic [CHAR_W-1:0] tx_head;
  logic rx_push;
  logic rx_room;
  logic [CHAR_W+ERR_W-1:0] rx_word;
  logic [LVL_W-1:0] rx_lvl;
  logic [LVL_W-1:0] tx_lvl;
  logic auto_rts;
  logic auto_cts;
  logic [LVL_W-1:0] halt_lvl;
  logic [LVL_W-1:0] resume_lvl;
  logic [LVL_W-1:0] rx_trig_lvl;
  logic [LVL_W-1:0] tx_trig_lvl;
  logic tx_go;

  function automatic logic [LVL_W-1:0] rx_sel(input logic [1:0] idx);
    case (idx)
      2'h0: rx_sel = RX_SEL_0;
      2'h1: rx_sel = RX_SEL_1;
      2'h2: rx_sel = RX_SEL_2;
      default: rx_sel = RX_SEL_3;
    endcase
  endfunction : rx_sel

  function automatic logic [LVL_W-1:0] tx_sel(input logic [1:0] idx);
    case (idx)
      2'h0: tx_sel = TX_SEL_0;
      2'h1: tx_sel = TX_SEL_1;
      2'h2: tx_sel = TX_SEL_2;
      default: tx_sel = TX_SEL_3;
    endcase
  endfunction : tx_sel

  function automatic logic [LVL_W-1:0] nib_lvl(input logic [3:0] nib);
    nib_lvl = LVL_W'({nib, NIB_UNIT_SH'(0)});
  endfunction : nib_lvl

  uart_fc_baud u_baud (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .divisor_i(divisor_i),
    .tick_o(tick)
  );

  // Both FIFOs are 64 deep; the receive side stores the three error bits with each byte.
  uart_fc_fifo #(.W(CHAR_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(tx_avail),
    .out_ready_i(tx_pop),
    .out_data_o(tx_head),
    .level_o(tx_lvl)
  );

  uart_fc_fifo #(.W(CHAR_W+ERR_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(rx_push),
    .in_ready_o(rx_room),
    .in_data_i(rx_word),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o({rx_err_o, rx_data_o}),
    .level_o(rx_lvl)
  );

  assign auto_rts = enhanced_features_reg_i[EFR_AUTO_RTS];
  assign auto_cts = enhanced_features_reg_i[EFR_AUTO_CTS];

  always_comb begin
    if (transmission_control_reg_i == '0) begin
      halt_lvl = rx_sel(fifo_control_reg_i[FCR_RX_LSB +: 2]);
      resume_lvl = (fifo_control_reg_i[FCR_RX_LSB +: 2] == 2'h0) ? LVL_ZERO
                   : rx_sel(fifo_control_reg_i[FCR_RX_LSB +: 2] - 2'h1);
    end else begin
      halt_lvl = nib_lvl(transmission_control_reg_i[NIB_LO +: 4]);
      resume_lvl = nib_lvl(transmission_control_reg_i[NIB_HI +: 4]);
    end
    if (!fifo_en_i) begin
      rx_trig_lvl = LVL_ONE;
      tx_trig_lvl = LVL_ONE;
    end else if (trigger_level_reg_i == '0) begin
      rx_trig_lvl = rx_sel(fifo_control_reg_i[FCR_RX_LSB +: 2]);
      tx_trig_lvl = tx_sel(fifo_control_reg_i[FCR_TX_LSB +: 2]);
    end else begin
      rx_trig_lvl = nib_lvl(trigger_level_reg_i[NIB_HI +: 4]);
      tx_trig_lvl = nib_lvl(trigger_level_reg_i[NIB_LO +: 4]);
    end
  end

  // CTS is looked at only between characters; a drop mid-character lets it finish.
  assign tx_go = tx_avail && (!auto_cts || !cts_n_i);
  assign tx_pop = (st_reg.tx_st == TX_IDLE) && tx_go;
  // The receiver never checks RTS, so a character already in flight is still stored.
  assign rx_push = (st_reg.rx_st == RX_STOP) && tick && (st_reg.rx_cnt == OVS_LAST);
  assign rx_word = {st_reg.ovr_pend, (st_reg.rx_sh == '0) && !rxd_i, !rxd_i, st_reg.rx_sh};

  always_comb begin
    st_next = st_reg;
    // Strap is caught once after reset release, then the shared pins are decoded.
    if (!st_reg.strap_done) begin
      st_next.strap_done = 1'b1;
      st_next.i2c_mode = host_sel_i;
    end else if (st_reg.i2c_mode) begin
      st_next.i2c_addr = {addr_sel_hi_or_serial_in_i, addr_sel_lo_or_chip_select_n_i};
      st_next.spi_cs = 1'b0;
      st_next.spi_din = 1'b0;
    end else begin
      st_next.i2c_addr = 2'h0;
      st_next.spi_cs = !addr_sel_lo_or_chip_select_n_i;
      st_next.spi_din = addr_sel_hi_or_serial_in_i;
    end
    case (st_reg.tx_st)
      TX_IDLE: begin
        st_next.txd = LINE_IDLE;
        if (tx_pop) begin
          st_next.tx_st = TX_START;
          st_next.tx_sh = tx_head;
          st_next.tx_cnt = '0;
          st_next.txd = 1'b0;
        end
      end
      TX_START, TX_DATA, TX_STOP: begin
        if (tick) begin
          st_next.tx_cnt = st_reg.tx_cnt + 1'b1;
          if (st_reg.tx_cnt == OVS_LAST) begin
            if (st_reg.tx_st == TX_START) begin
              st_next.tx_st = TX_DATA;
              st_next.tx_bit = '0;
              st_next.txd = st_reg.tx_sh[0];
            end else if (st_reg.tx_st == TX_DATA && st_reg.tx_bit != BIT_LAST) begin
              st_next.tx_bit = st_reg.tx_bit + 1'b1;
              st_next.tx_sh = {1'b0, st_reg.tx_sh[CHAR_W-1:1]};
              st_next.txd = st_reg.tx_sh[1];
            end else if (st_reg.tx_st == TX_DATA) begin
              st_next.tx_st = TX_STOP;
              st_next.txd = LINE_IDLE;
            end else begin
              st_next.tx_st = TX_IDLE;
            end
          end
        end
      end
      default: st_next.tx_st = TX_IDLE;
    endcase
    case (st_reg.rx_st)
      RX_IDLE: begin
        if (!rxd_i) begin
          st_next.rx_st = RX_START;
          st_next.rx_cnt = '0;
        end
      end
      RX_START: begin
        if (tick) begin
          st_next.rx_cnt = st_reg.rx_cnt + 1'b1;
          if (st_reg.rx_cnt == OVS_MID) begin
            st_next.rx_st = rxd_i ? RX_IDLE : RX_DATA;
            st_next.rx_cnt = '0;
            st_next.rx_bit = '0;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          st_next.rx_cnt = st_reg.rx_cnt + 1'b1;
          if (st_reg.rx_cnt == OVS_LAST) begin
            st_next.rx_sh = {rxd_i, st_reg.rx_sh[CHAR_W-1:1]};
            st_next.rx_bit = st_reg.rx_bit + 1'b1;
            if (st_reg.rx_bit == BIT_LAST) begin
              st_next.rx_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          st_next.rx_cnt = st_reg.rx_cnt + 1'b1;
          if (rx_push) begin
            st_next.rx_st = RX_IDLE;
          end
        end
      end
      default: st_next.rx_st = RX_IDLE;
    endcase
    // A lost character marks the next stored one; a new loss in the same cycle wins.
    if (rx_push) begin
      st_next.ovr_pend = !rx_room;
    end
    if (!auto_rts) begin
      st_next.rts_n = RTS_OFF;
    end else if (!st_reg.rts_n && rx_lvl >= halt_lvl) begin
      st_next.rts_n = RTS_OFF;
    end else if (st_reg.rts_n && rx_lvl <= resume_lvl && rx_lvl < halt_lvl) begin
      st_next.rts_n = 1'b0;
    end
    st_next.cts_prev = cts_n_i;
    st_next.cts_change = !auto_cts && (cts_n_i != st_reg.cts_prev);
    st_next.rx_trig = rx_lvl >= rx_trig_lvl;
    st_next.tx_trig = (LVL_W'(FIFO_DEPTH) - tx_lvl) >= tx_trig_lvl;
    // Status is a registered snapshot, so reading it never touches the data paths.
    st_next.status = {st_reg.tx_st == TX_IDLE && !tx_avail, !tx_avail, !rx_room,
                      !st_reg.rts_n, !cts_n_i, st_reg.ovr_pend, st_reg.rx_st != RX_IDLE, rx_valid_o};
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.tx_st <= TX_IDLE;
      st_reg.rx_st <= RX_IDLE;
      st_reg.txd <= LINE_IDLE;
      st_reg.rts_n <= RTS_OFF;
      st_reg.cts_prev <= RTS_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  assign i2c_mode_o = st_reg.i2c_mode;
  assign i2c_addr_sel_o = st_reg.i2c_addr;
  assign spi_cs_active_o = st_reg.spi_cs;
  assign spi_data_in_o = st_reg.spi_din;
  assign txd_o = st_reg.txd;
  assign rts_n_o = st_reg.rts_n;
  assign cts_change_o = st_reg.cts_change;
  assign rx_trig_o = st_reg.rx_trig;
  assign tx_trig_o = st_reg.tx_trig;
  assign status_o = st_reg.status;
  assign rx_level_o = rx_lvl;
  assign tx_level_o = tx_lvl;

  a_rts_halt: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    auto_rts && !rts_n_o && rx_lvl >= halt_lvl |=> rts_n_o)
    else $error("RTS not dropped at halt level");
  a_rts_resume: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    auto_rts && rts_n_o && rx_lvl <= resume_lvl && rx_lvl < halt_lvl |=> !rts_n_o)
    else $error("RTS not restored at resume level");
  a_cts_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    auto_cts && cts_n_i && st_reg.tx_st == TX_IDLE |=> txd_o && st_reg.tx_st == TX_IDLE)
    else $error("Character started while CTS deasserted");
  a_tx_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !auto_cts && tx_avail && st_reg.tx_st == TX_IDLE |=> !txd_o ##1 !txd_o)
    else $error("Queued character not started");
  a_cts_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    auto_cts |=> !cts_change_o)
    else $error("CTS event raised under auto CTS");
  a_cts_event: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !auto_cts && $changed(cts_n_i) |=> cts_change_o)
    else $error("CTS change not reported");
  a_trig_single: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !fifo_en_i && rx_lvl != LVL_ZERO |=> rx_trig_o)
    else $error("Disabled FIFO trigger is not one character");
  a_strap_mode: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_reg.strap_done && !i2c_mode_o && !addr_sel_lo_or_chip_select_n_i |=> spi_cs_active_o && i2c_addr_sel_o == 2'h0)
    else $error("SPI select decode wrong");
endmodule : uart_fc_top
`default_nettype wire

// *** sim/remote_uart.sv ***
// Remote UART partner: an 8N1 sender and receiver at BIT_CYC clocks per bit, plus a CTS output.
// Assumes the block runs its baud generator with divisor 1, which gives 16 clocks per bit.
`timescale 1ns/10ps
`default_nettype none
module remote_uart #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic cts_n_o
);
  logic [7:0] got_q[$];
  logic [7:0] shift_reg;

  initial begin
    rxd_o = 1'b1;
    cts_n_o = 1'b1; // CTS starts deasserted, so nothing may be sent yet.
  end

  // The bench can drop CTS in mid character to stop the character after it.
  task automatic set_cts(input logic level_n);
    @(negedge clk_i);
    cts_n_o = level_n;
  endtask : set_cts

  // RTS is not consulted here, so the bench alone decides whether to overrun the halt level.
  task automatic send_char(input logic [7:0] value);
    logic [9:0] frame;
    frame = {1'b1, value, 1'b0};
    for (int b = 0; b < 10; b++) begin
      @(negedge clk_i);
      rxd_o = frame[b];
      repeat (BIT_CYC - 1) @(negedge clk_i);
    end
  endtask : send_char

  // Samples each bit in its middle, least significant bit first.
  always begin
    @(negedge txd_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int b = 0; b < 8; b++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      shift_reg[b] = txd_i;
    end
    repeat (BIT_CYC) @(posedge clk_i);
    got_q.push_back(shift_reg);
  end
endmodule : remote_uart
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the UART trigger level and hardware flow control block.
// Assumes the remote_uart partner model and divisor 1, so one bit lasts 16 clocks; only the baud test changes it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("wrong value %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module tb;
  import uart_fc_pkg::*;
  logic clk_sys_i;
  logic rst;
  logic host_sel;
  logic sel_hi;
  logic sel_lo;
  logic fifo_en;
  logic [7:0] fifo_control_reg;
  logic [7:0] trigger_level_reg;
  logic [7:0] transmission_control_reg;
  logic [7:0] enhanced_features_reg;
  logic [CHAR_W-1:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic rx_ready;
  logic i2c_mode;
  logic [1:0] i2c_addr;
  logic spi_cs;
  logic spi_din;
  logic [CHAR_W-1:0] rx_data;
  logic [ERR_W-1:0] rx_err;
  logic rx_valid;
  logic [LVL_W-1:0] rx_level;
  logic [LVL_W-1:0] tx_level;
  logic rx_trig;
  logic tx_trig;
  logic cts_change;
  logic [7:0] status;
  logic rxd;
  logic txd;
  logic cts_n;
  logic rts_n;
  logic [DIV_W-1:0] divisor;
  int err_count = 0;
  int checks_done = 0;
  int cts_pulses = 0;

  uart_fc_top DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst), .host_sel_i(host_sel),
    .addr_sel_hi_or_serial_in_i(sel_hi), .addr_sel_lo_or_chip_select_n_i(sel_lo),
    .i2c_mode_o(i2c_mode), .i2c_addr_sel_o(i2c_addr), .spi_cs_active_o(spi_cs), .spi_data_in_o(spi_din),
    .fifo_en_i(fifo_en), .fifo_control_reg_i(fifo_control_reg), .trigger_level_reg_i(trigger_level_reg),
    .transmission_control_reg_i(transmission_control_reg), .enhanced_features_reg_i(enhanced_features_reg), .divisor_i(divisor),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .rx_data_o(rx_data), .rx_err_o(rx_err), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .rx_level_o(rx_level), .tx_level_o(tx_level), .rx_trig_o(rx_trig), .tx_trig_o(tx_trig),
    .cts_change_o(cts_change), .status_o(status), .rxd_i(rxd), .txd_o(txd),
    .cts_n_i(cts_n), .rts_n_o(rts_n)
  );

  remote_uart #(.BIT_CYC(16)) peer (.clk_i(clk_sys_i), .txd_i(txd), .rxd_o(rxd), .cts_n_o(cts_n));

  initial begin
    clk_sys_i = 1'b0;
  end
  always #4 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i) begin
    if (cts_change === 1'b1) begin
      cts_pulses++;
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // The strap is sampled only once after release, so each host mode needs its own reset.
  // The host serial clock is not a pin of this block; a host idles it high for I2C, low for SPI.
  task automatic do_reset(input logic sel);
    @(negedge clk_sys_i);
    rst = 1'b1;
    host_sel = sel;
    repeat (20) @(negedge clk_sys_i);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys_i);
  endtask : do_reset

  task automatic push_tx(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys_i);
      tx_valid = 1'b1;
      tx_data = 8'(base + i);
    end
    @(negedge clk_sys_i);
    tx_valid = 1'b0;
    repeat (2) @(negedge clk_sys_i);
  endtask : push_tx

  task automatic pop_rx(input logic [7:0] exp);
    repeat (2) @(negedge clk_sys_i);
    `CHK("rx valid", 1'b1, rx_valid)
    `CHK("rx data", exp, rx_data)
    `CHK("rx error bits", 3'h0, rx_err)
    rx_ready = 1'b1;
    @(negedge clk_sys_i);
    rx_ready = 1'b0;
  endtask : pop_rx

  task automatic t_straps();
    sel_hi = 1'b1;
    sel_lo = 1'b0;
    do_reset(1'b1);
    `CHK("i2c mode", 1'b1, i2c_mode)
    `CHK("i2c address", 2'h2, i2c_addr)
    `CHK("spi select in i2c", 1'b0, spi_cs)
    `CHK("rts after reset", RTS_OFF, rts_n)
    `CHK("tx ready after reset", 1'b1, tx_ready)
    `CHK("tx trigger after reset", 1'b1, tx_trig)
    peer.send_char(8'hA5);
    `CHK("rx trigger at one", 1'b1, rx_trig)
    pop_rx(8'hA5);
    do_reset(1'b0);
    `CHK("spi mode", 1'b0, i2c_mode)
    `CHK("spi data in", 1'b1, spi_din)
    `CHK("spi select low", 1'b1, spi_cs)
    sel_lo = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    `CHK("spi select high", 1'b0, spi_cs)
    $display("test straps done");
  endtask : t_straps

  // Fills the receiver one character past the halt level, then drains it down to the resume level.
  task automatic t_rts(input logic [7:0] tcr_v, input logic [7:0] fcr_v, input int halt, input int resume);
    transmission_control_reg = tcr_v;
    fifo_control_reg = fcr_v;
    enhanced_features_reg = 8'h40;
    fifo_en = 1'b1;
    trigger_level_reg = 8'h00;
    repeat (2) @(negedge clk_sys_i);
    for (int i = 0; i < halt; i++) begin
      `CHK("rts below halt", 1'b0, rts_n)
      `CHK("rx trigger below", 1'b0, rx_trig)
      peer.send_char(8'(8'h30 + i));
    end
    repeat (2) @(negedge clk_sys_i);
    `CHK("rts at halt", 1'b1, rts_n)
    `CHK("rx trigger reached", 1'b1, rx_trig)
    `CHK("status rts", 1'b0, status[4])
    `CHK("status data", 1'b1, status[0])
    peer.send_char(8'(8'h30 + halt));
    `CHK("late character kept", 7'(halt + 1), rx_level)
    for (int i = 0; i <= halt - resume; i++) begin
      `CHK("rts held off", 1'b1, rts_n)
      pop_rx(8'(8'h30 + i));
    end
    repeat (2) @(negedge clk_sys_i);
    `CHK("rx level at resume", 7'(resume), rx_level)
    `CHK("rts resumed", 1'b0, rts_n)
    for (int i = halt - resume + 1; i <= halt; i++) begin
      pop_rx(8'(8'h30 + i));
    end
    $display("test rts halt %0d resume %0d done", halt, resume);
  endtask : t_rts

  task automatic t_cts();
    int n;
    enhanced_features_reg = 8'h80;
    trigger_level_reg = 8'h22;
    peer.set_cts(1'b1);
    push_tx(56, 0);
    `CHK("tx level", 7'h38, tx_level)
    `CHK("tx trigger room", 1'b1, tx_trig)
    `CHK("line held idle", LINE_IDLE, txd)
    push_tx(1, 56);
    `CHK("tx trigger short", 1'b0, tx_trig)
    peer.set_cts(1'b0);
    for (n = 0; n < 50 && txd !== 1'b0; n++) @(negedge clk_sys_i);
    `CHK("start after cts", 1'b0, txd)
    repeat (40) @(negedge clk_sys_i);
    peer.set_cts(1'b1);
    repeat (400) @(negedge clk_sys_i);
    `CHK("one char sent", 1, peer.got_q.size())
    `CHK("tx level held", 7'h38, tx_level)
    `CHK("no cts event", 0, cts_pulses)
    enhanced_features_reg = 8'h00;
    for (n = 0; n < 10000 && tx_level !== 7'h00; n++) @(negedge clk_sys_i);
    repeat (200) @(negedge clk_sys_i);
    `CHK("all chars sent", 57, peer.got_q.size())
    for (int i = 0; i < peer.got_q.size(); i++) begin
      `CHK("tx char", 8'(i), peer.got_q[i])
    end
    peer.set_cts(1'b0);
    repeat (3) @(negedge clk_sys_i);
    `CHK("cts event", 1, cts_pulses)
    $display("test cts done");
  endtask : t_cts

  // Four ones in a row last 64 baud ticks whatever the tick phase, so the run shows the divisor exactly.
  task automatic t_baud(input logic [DIV_W-1:0] div, input int run);
    int n;
    divisor = div;
    push_tx(1, 8'h0F);
    for (n = 0; n < 100 && txd !== 1'b1; n++) @(negedge clk_sys_i);
    for (n = 0; n < 300 && txd === 1'b1; n++) @(negedge clk_sys_i);
    `CHK("ones run length", run, n)
    repeat (200) @(negedge clk_sys_i);
    if (div == 16'h0001) begin
      `CHK("char at divisor one", 8'h0F, peer.got_q[peer.got_q.size() - 1])
    end
    $display("test baud divisor %0d done", div);
  endtask : t_baud

  initial begin
    repeat (40000) @(posedge clk_sys_i);
    err_count++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    rst = 1'b1;
    host_sel = 1'b1;
    sel_hi = 1'b0;
    sel_lo = 1'b0;
    fifo_en = 1'b0;
    fifo_control_reg = 8'h00;
    trigger_level_reg = 8'h00;
    transmission_control_reg = 8'h00;
    enhanced_features_reg = 8'h00;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    divisor = 16'h0001;
    t_straps();
    t_rts(8'h12, 8'h00, 8, 4);
    t_rts(8'h00, 8'h40, 16, 8);
    t_cts();
    t_baud(16'h0001, 32'h40);
    t_baud(16'h0002, 32'h80);
    stop_test();
  end
endmodule : tb
`default_nettype wire
